// ---- src/ssbg_regs.svh ----
// register offsets, field positions and reset values of the serial status and bit-rate block
`ifndef SSBG_REGS_SVH
`define SSBG_REGS_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define SSBG_OFF_STATUS_TWO   8'h00
`define SSBG_OFF_DIVISOR      8'h04
`define SSBG_OFF_MODE         8'h08
`define SSBG_OFF_RX_STATUS    8'h0C
`define SSBG_OFF_RX_FIFO      8'h10

// ------------------------------------------------------------
// serial_status_two fields
// ------------------------------------------------------------
`define SSBG_ST2_TX_MSB       7
`define SSBG_ST2_RX_MSB       6
`define SSBG_ST2_RATIO_HI     5
`define SSBG_ST2_RATIO_LO     4
`define SSBG_ST2_RX_MPB       3
`define SSBG_ST2_TX_MPB       2
`define SSBG_ST2_ERR_IGNORE   1
`define SSBG_ST2_OVERRUN      0

// ------------------------------------------------------------
// mode register fields
// ------------------------------------------------------------
`define SSBG_MODE_RX_EN       0
`define SSBG_MODE_TX_EN       1
`define SSBG_MODE_SYNC        2
`define SSBG_MODE_MULTIPROC   3
`define SSBG_MODE_IRDA        4
`define SSBG_MODE_PRESC_LO    5
`define SSBG_MODE_PRESC_HI    6

// ------------------------------------------------------------
// reset values and answers
// ------------------------------------------------------------
`define SSBG_RST_STATUS_TWO   8'h20
`define SSBG_RST_DIVISOR      8'hFF
`define SSBG_RST_MODE         8'h00
`define SSBG_RESP_OKAY        2'b00
`define SSBG_RESP_SLVERR      2'b10

`endif

// ---- src/ssbg_pkg.sv ----
// types shared by the serial status and bit-rate block
package ssbg_pkg;

  // ------------------------------------------------------------
  // characters between the block and the shift engines
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic       rx_multiproc_bit;
    logic       frame_err;
    logic       parity_err;
  } ssbg_rx_char_t;

  typedef struct packed {
    logic [7:0] data;
    logic       rx_multiproc_bit;
    logic       mpb_en;
  } ssbg_tx_char_t;

  // ------------------------------------------------------------
  // base clock to bit rate ratio codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SSBG_RATIO_X4  = 2'b00,
    SSBG_RATIO_X8  = 2'b01,
    SSBG_RATIO_X16 = 2'b10,
    SSBG_RATIO_BAD = 2'b11
  } ssbg_ratio_t;

endpackage : ssbg_pkg

// ---- src/ssbg_top.sv ----
// serial status two register, bit-rate generator and receive fifo behind an axi4-lite slave
`include "ssbg_regs.svh"

module ssbg_top #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  standby,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  rx_char_valid,
  input  wire ssbg_pkg::ssbg_rx_char_t rx_char,
  output logic                       rx_suspend,
  input  wire logic                  tx_load,
  input  wire logic [7:0]            tx_data,
  output logic                       tx_char_valid,
  output ssbg_pkg::ssbg_tx_char_t    tx_char,
  output logic                       tx_suspend,
  output logic                       base_tick,
  output logic                       bit_tick
);

  localparam int AW = $clog2(FIFO_DEPTH);

  if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH)
  begin : g_depth_check
    $error("ssbg_top: FIFO_DEPTH must be a power of two, at least 2");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic              clr;
  logic [7:0]        status_two_reg;
  logic [7:0]        divisor_reg;
  logic [7:0]        mode_reg;
  logic              overrun_seen_reg;
  logic              err_halt_reg;
  logic [8:0]        fifo_mem [FIFO_DEPTH];
  logic [AW-1:0]     wptr_reg;
  logic [AW-1:0]     rptr_reg;
  logic [AW:0]       count_reg;
  logic [5:0]        presc_cnt_reg;
  logic [7:0]        div_cnt_reg;
  logic              half_reg;
  logic [3:0]        base_cnt_reg;
  logic              aw_got_reg;
  logic              w_got_reg;
  logic [7:0]        awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              base_tick_reg;
  logic              bit_tick_reg;
  logic              tx_valid_reg;
  ssbg_pkg::ssbg_tx_char_t tx_char_reg;

  assign clr = !aresetn || standby;

  // mode decode
  logic       rx_en;
  logic       tx_en;
  logic       sync_mode;
  logic       multiproc;
  logic       irda;
  logic [1:0] presc_sel;
  logic       overrun;
  logic       err_ignore;

  assign rx_en      = mode_reg[`SSBG_MODE_RX_EN];
  assign tx_en      = mode_reg[`SSBG_MODE_TX_EN];
  assign sync_mode  = mode_reg[`SSBG_MODE_SYNC];
  assign multiproc  = mode_reg[`SSBG_MODE_MULTIPROC];
  assign irda       = mode_reg[`SSBG_MODE_IRDA];
  assign presc_sel  = mode_reg[`SSBG_MODE_PRESC_HI:`SSBG_MODE_PRESC_LO];
  assign overrun    = status_two_reg[`SSBG_ST2_OVERRUN];
  assign err_ignore = status_two_reg[`SSBG_ST2_ERR_IGNORE];

  // ------------------------------------------------------------
  // axi4-lite handshakes
  // ------------------------------------------------------------
  logic        aw_hs;
  logic        w_hs;
  logic        do_write;
  logic [7:0]  waddr;
  logic [31:0] wdata;
  logic        wr_lane0;
  logic        ar_hs;

  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready  = !w_got_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign do_write      = (aw_got_reg || aw_hs) && (w_got_reg || w_hs) && !bvalid_reg;
  assign waddr         = aw_got_reg ? awaddr_reg : s_axi_awaddr;
  assign wdata         = w_got_reg ? wdata_reg : s_axi_wdata;
  assign wr_lane0      = w_got_reg ? wstrb_reg[0] : s_axi_wstrb[0];

  always_ff @(posedge aclk)
  begin
    if (clr)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end
    else if (do_write)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // write decode
  logic wr_st2;
  logic wr_div;
  logic wr_mode;
  logic wr_rxst;
  logic wr_hit;

  always_comb
  begin
    wr_st2  = 1'b0;
    wr_div  = 1'b0;
    wr_mode = 1'b0;
    wr_rxst = 1'b0;
    wr_hit  = 1'b1;
    if (waddr == `SSBG_OFF_STATUS_TWO)
      wr_st2 = do_write && wr_lane0;
    else if (waddr == `SSBG_OFF_DIVISOR)
      wr_div = do_write && wr_lane0;
    else if (waddr == `SSBG_OFF_MODE)
      wr_mode = do_write && wr_lane0;
    else if (waddr == `SSBG_OFF_RX_STATUS)
      wr_rxst = do_write && wr_lane0;
    else if (waddr != `SSBG_OFF_RX_FIFO)
      wr_hit = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (clr)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `SSBG_RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `SSBG_RESP_OKAY : `SSBG_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ------------------------------------------------------------
  // receive path and fifo
  // ------------------------------------------------------------
  logic       rx_err;
  logic       rx_take;
  logic       push;
  logic       pop;
  logic       overrun_set;
  logic [7:0] rx_ordered;
  logic [7:0] rx_rev;
  logic [7:0] tx_rev;

  // plain bit reversal, kept out of the conditional operators
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      rx_rev[i] = rx_char.data[7 - i];
      tx_rev[i] = tx_data[7 - i];
    end
  end

  assign rx_err      = rx_char.frame_err || rx_char.parity_err;
  assign rx_take     = rx_char_valid && rx_en && !overrun && !err_halt_reg;
  assign push        = rx_take && (count_reg != FIFO_DEPTH[AW:0]);
  assign overrun_set = rx_take && (count_reg == FIFO_DEPTH[AW:0]);
  assign pop         = ar_hs && (s_axi_araddr == `SSBG_OFF_RX_FIFO) && (count_reg != '0);
  assign rx_ordered  = status_two_reg[`SSBG_ST2_RX_MSB] ? rx_rev : rx_char.data;

  always_ff @(posedge aclk)
  begin
    if (push)
      fifo_mem[wptr_reg] <= {rx_err, rx_ordered};
  end

  always_ff @(posedge aclk)
  begin
    if (clr)
    begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wptr_reg <= wptr_reg + 1'b1;
      if (pop)
        rptr_reg <= rptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

  // halt after a stored error unless errors are ignored; cleared by writing 0
  always_ff @(posedge aclk)
  begin
    if (clr)
      err_halt_reg <= 1'b0;
    else if (push && rx_err && !err_ignore)
      err_halt_reg <= 1'b1;
    else if (wr_rxst && !wdata[0])
      err_halt_reg <= 1'b0;
  end

  assign rx_suspend = overrun || err_halt_reg;

  // ------------------------------------------------------------
  // serial status two
  // ------------------------------------------------------------
  logic rd_st2;

  assign rd_st2 = ar_hs && (s_axi_araddr == `SSBG_OFF_STATUS_TWO);

  always_ff @(posedge aclk)
  begin
    if (clr)
      overrun_seen_reg <= 1'b0;
    else if (rd_st2 && overrun)
      overrun_seen_reg <= 1'b1;
    else if (!overrun)
      overrun_seen_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (clr)
      status_two_reg <= `SSBG_RST_STATUS_TWO;
    else
    begin
      if (wr_st2)
      begin
        status_two_reg[7:4]                  <= wdata[7:4];
        status_two_reg[`SSBG_ST2_TX_MPB]     <= wdata[`SSBG_ST2_TX_MPB];
        status_two_reg[`SSBG_ST2_ERR_IGNORE] <= wdata[`SSBG_ST2_ERR_IGNORE];
      end
      // set wins over a clearing write in the same cycle
      if (overrun_set)
        status_two_reg[`SSBG_ST2_OVERRUN] <= 1'b1;
      else if (wr_st2 && !wdata[`SSBG_ST2_OVERRUN] && overrun_seen_reg)
        status_two_reg[`SSBG_ST2_OVERRUN] <= 1'b0;
      // only taken characters update it, so disabled receive keeps the old bit
      if (rx_take && !sync_mode && multiproc)
        status_two_reg[`SSBG_ST2_RX_MPB] <= rx_char.rx_multiproc_bit;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (clr)
      divisor_reg <= `SSBG_RST_DIVISOR;
    else if (wr_div)
      divisor_reg <= wdata[7:0];
  end

  always_ff @(posedge aclk)
  begin
    if (clr)
      mode_reg <= `SSBG_RST_MODE;
    else if (wr_mode)
      mode_reg <= wdata[7:0];
  end

  // ------------------------------------------------------------
  // bit-rate generator
  // ------------------------------------------------------------
  logic [5:0] presc_top;
  logic       presc_tick;
  logic       div_reload;
  logic [3:0] base_top;
  logic       gen_run;

  assign gen_run = rx_en || tx_en;

  always_comb
  begin
    case (presc_sel)
      2'b00:   presc_top = 6'd0;
      2'b01:   presc_top = 6'd3;
      2'b10:   presc_top = 6'd15;
      default: presc_top = 6'd63;
    endcase
  end

  // sync uses two base periods per bit, async the ratio field
  always_comb
  begin
    if (sync_mode)
      base_top = 4'd1;
    else
    begin
      case (ssbg_pkg::ssbg_ratio_t'(status_two_reg[5:4]))
        ssbg_pkg::SSBG_RATIO_X4: base_top = 4'd3;
        ssbg_pkg::SSBG_RATIO_X8: base_top = 4'd7;
        default:                 base_top = 4'd15;
      endcase
    end
  end

  assign presc_tick = gen_run && (presc_cnt_reg >= presc_top);
  // compare with >= so a smaller divisor takes effect by the next reload
  assign div_reload = presc_tick && (div_cnt_reg >= divisor_reg);

  always_ff @(posedge aclk)
  begin
    if (clr || !gen_run)
    begin
      presc_cnt_reg <= 6'd0;
      div_cnt_reg   <= 8'd0;
      half_reg      <= 1'b0;
      base_cnt_reg  <= 4'd0;
      base_tick_reg <= 1'b0;
      bit_tick_reg  <= 1'b0;
    end
    else
    begin
      base_tick_reg <= 1'b0;
      bit_tick_reg  <= 1'b0;
      presc_cnt_reg <= presc_tick ? 6'd0 : presc_cnt_reg + 6'd1;
      if (div_reload)
      begin
        div_cnt_reg <= 8'd0;
        half_reg    <= !half_reg;
        // base period is two reloads: (N+1)*2*4^n clocks
        if (half_reg)
        begin
          base_tick_reg <= 1'b1;
          if (base_cnt_reg >= base_top)
          begin
            base_cnt_reg <= 4'd0;
            bit_tick_reg <= 1'b1;
          end
          else
            base_cnt_reg <= base_cnt_reg + 4'd1;
        end
      end
      else if (presc_tick)
        div_cnt_reg <= div_cnt_reg + 8'd1;
    end
  end

  assign base_tick = base_tick_reg;
  assign bit_tick  = bit_tick_reg;

  // ------------------------------------------------------------
  // transmit character preparation
  // ------------------------------------------------------------
  logic mpb_used;

  assign mpb_used   = tx_en && !sync_mode && !irda && multiproc;
  assign tx_suspend = sync_mode && overrun;

  always_ff @(posedge aclk)
  begin
    if (clr)
    begin
      tx_valid_reg <= 1'b0;
      tx_char_reg  <= '0;
    end
    else
    begin
      tx_valid_reg <= tx_load && tx_en && !tx_suspend;
      if (tx_load && tx_en && !tx_suspend)
      begin
        tx_char_reg.data   <= status_two_reg[`SSBG_ST2_TX_MSB] ? tx_rev : tx_data;
        tx_char_reg.rx_multiproc_bit    <= mpb_used && status_two_reg[`SSBG_ST2_TX_MPB];
        tx_char_reg.mpb_en <= mpb_used;
      end
    end
  end

  assign tx_char_valid = tx_valid_reg;
  assign tx_char       = tx_char_reg;

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (s_axi_araddr == `SSBG_OFF_STATUS_TWO)
      rd_word[7:0] = status_two_reg;
    else if (s_axi_araddr == `SSBG_OFF_DIVISOR)
      rd_word[7:0] = divisor_reg;
    else if (s_axi_araddr == `SSBG_OFF_MODE)
      rd_word[7:0] = mode_reg;
    else if (s_axi_araddr == `SSBG_OFF_RX_STATUS)
    begin
      rd_word[0]      = err_halt_reg;
      rd_word[12:8]   = 5'(count_reg);
    end
    else if (s_axi_araddr == `SSBG_OFF_RX_FIFO)
      rd_word[8:0] = (count_reg != '0) ? fifo_mem[rptr_reg] : 9'h000;
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (clr)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `SSBG_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? `SSBG_RESP_OKAY : `SSBG_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

endmodule : ssbg_top

// ---- verification/ssbg_chk.sv ----
// assertion checker for the serial status and bit-rate block
module ssbg_chk (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    standby,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic                    tx_load,
  input wire logic                    tx_char_valid,
  input wire ssbg_pkg::ssbg_tx_char_t tx_char,
  input wire logic                    tx_suspend,
  input wire logic                    rx_suspend,
  input wire logic                    base_tick,
  input wire logic                    bit_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || standby);

  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_wr_answer;
    s_wr_both |=> s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  property p_rd_answer;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_tx_mpb;
    tx_char_valid && !tx_char.mpb_en |-> !tx_char.rx_multiproc_bit;
  endproperty
  a_tx_mpb: assert property (p_tx_mpb) else $error("multiproc bit leaked");
  property p_tx_stop;
    tx_suspend && tx_load |=> !tx_char_valid;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("sent while suspended");
  property p_rx_keep;
    rx_suspend && !s_axi_awvalid && !s_axi_wvalid |=> rx_suspend;
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("suspend lost");
  property p_bit_base;
    bit_tick |-> base_tick;
  endproperty
  a_bit_base: assert property (p_bit_base) else $error("bit tick off grid");
  property p_base_gap;
    base_tick |=> !base_tick;
  endproperty
  a_base_gap: assert property (p_base_gap) else $error("base ticks adjacent");
endmodule : ssbg_chk

bind ssbg_top ssbg_chk u_chk (.*);

// ---- verification/ssbg_station.sv ----
// remote serial station model feeding received characters
module ssbg_station (
  input  wire logic              aclk,
  output logic                   rx_char_valid,
  output ssbg_pkg::ssbg_rx_char_t rx_char
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // character delivery
  // ------------------------------------------------------------
  initial
  begin
    rx_char_valid = 1'h0;
    rx_char = '0;
  end

  // gap of at least one cycle, so valid is never driven twice at one edge
  task automatic send(input logic [7:0] d, input logic m, input logic fe, input logic pe, input int gap);
    repeat (gap) @(posedge aclk);
    rx_char_valid <= 1'h1;
    rx_char <= {d, m, fe, pe};
    @(posedge aclk);
    rx_char_valid <= 1'h0;
    // stale data inverted so nothing relies on it
    rx_char <= ~rx_char;
  endtask : send
endmodule : ssbg_station

// ---- verification/ssbg_top_bench.sv ----
// self-checking bench of the serial status and bit-rate block
`include "ssbg_regs.svh"
module ssbg_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    aclk, aresetn, standby, tx_load, tx_char_valid, tx_suspend;
  logic [7:0]              s_axi_awaddr, s_axi_araddr, tx_data, d;
  logic [31:0]             s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              s_axi_bresp, s_axi_rresp, rs;
  logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                    s_axi_rvalid, s_axi_rready, rx_char_valid, rx_suspend, base_tick, bit_tick;
  logic                    msb, mp, en;
  logic [9:0]              te;
  ssbg_pkg::ssbg_rx_char_t rx_char;
  ssbg_pkg::ssbg_tx_char_t tx_char;
  int                      error_cnt, cmp_count, c, nn;
  logic [7:0]              q[$];
  logic [7:0]              mds[4] = '{8'h0A, 8'h0E, 8'h1A, 8'h02};
  int                      pns[8] = '{0, 1, 2, 3, 0, 0, 1, 0};
  int                      cds[8] = '{0, 0, 0, 0, 1, 2, 2, 0};

  ssbg_top dut (.*);
  ssbg_station stn (.aclk(aclk), .rx_char_valid(rx_char_valid), .rx_char(rx_char));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial
  begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction : rev

  // bit period in clocks: divisor, prescale, ratio code, sync
  function automatic int exp_bit(input int n, input int p, input int cd, input int sy);
    return (n + 1) * (4 ** p) * (sy ? 4 : (cd == 0 ? 8 : (cd == 1 ? 16 : 32)));
  endfunction : exp_bit

  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk_w

  task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected response at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk_r

  task automatic end_of_test;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    // one edge between transfers, so bready never changes twice in a step
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, rd_v, rs);
    chk_w(rd_v, e);
  endtask : rdc

  task automatic txc(input logic [7:0] v, input logic ok, input logic [9:0] e);
    tx_data <= v;
    tx_load <= 1'h1;
    @(posedge aclk);
    tx_load <= 1'h0;
    @(posedge aclk);
    if (ok) chk_w({tx_char_valid, tx_char}, {1'h1, e});
    else chk_w(tx_char_valid, 1'h0);
  endtask : txc

  // interval between bit ticks, after two to let a new setting settle
  task automatic meas(output int n);
    for (int i = 0; i < 3; i++)
    begin
      n = 0;
      do
      begin
        @(posedge aclk);
        n++;
      end while (!bit_tick);
    end
  endtask : meas

  initial
  begin
    #500_000;
    error_cnt++;
    $display("unexpected timeout at %0t", $time);
    end_of_test();
  end

  initial
  begin
    void'($urandom(32'h6618_9080));
    {aresetn, standby, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tx_load} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_data} = '0;
    s_axi_wstrb = 4'hF;
    error_cnt = 0;
    cmp_count = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rdc(8'h00, 32'h0000_0020);
    rdc(8'h04, 32'h0000_00FF);
    rd(8'h20, rd_v, rs);
    chk_r(rs, `SSBG_RESP_SLVERR);
    wr(8'h20, 32'h0000_0000, rs);
    chk_r(rs, `SSBG_RESP_SLVERR);
    wr(8'h00, 32'h0000_00EF, rs);
    chk_r(rs, `SSBG_RESP_OKAY);
    rdc(8'h00, 32'h0000_00E6);
    for (int i = 0; i < 4; i++)
    begin
      d = (i == 0) ? 8'h00 : ((i == 1) ? 8'hFF : 8'($urandom));
      wr(8'h04, {24'h00_0000, d}, rs);
      rdc(8'h04, {24'h00_0000, d});
    end
    for (int i = 0; i < 16; i++)
    begin
      msb = i[2];
      mp = i[3];
      en = (i % 4 == 0);
      d = 8'($urandom);
      wr(8'h08, {24'h00_0000, mds[i % 4]}, rs);
      wr(8'h00, {24'h00_0000, msb, 3'h2, 1'h0, mp, 2'h0}, rs);
      te = {msb ? rev(d) : d, mp & en, en};
      txc(d, 1'h1, te);
    end
    wr(8'h08, 32'h0000_0009, rs);
    wr(8'h00, 32'h0000_0060, rs);
    d = 8'($urandom);
    stn.send(d, 1'h1, 1'h0, 1'h0, 1);
    rdc(8'h00, 32'h0000_0068);
    wr(8'h08, 32'h0000_0008, rs);
    stn.send(~d, 1'h0, 1'h0, 1'h0, 1);
    rdc(8'h00, 32'h0000_0068);
    rdc(8'h0C, 32'h0000_0100);
    rdc(8'h10, {24'h00_0000, rev(d)});
    wr(8'h08, 32'h0000_0001, rs);
    wr(8'h00, 32'h0000_0020, rs);
    stn.send(8'h5A, 1'h0, 1'h1, 1'h0, 1);
    stn.send(8'hA5, 1'h0, 1'h0, 1'h0, 2);
    rdc(8'h0C, 32'h0000_0101);
    chk_w(rx_suspend, 1'h1);
    rdc(8'h10, 32'h0000_015A);
    wr(8'h0C, 32'h0000_0000, rs);
    wr(8'h00, 32'h0000_0022, rs);
    stn.send(8'h3C, 1'h0, 1'h0, 1'h1, 1);
    stn.send(8'hC3, 1'h0, 1'h0, 1'h0, 3);
    rdc(8'h0C, 32'h0000_0200);
    rdc(8'h10, 32'h0000_013C);
    rdc(8'h10, 32'h0000_00C3);
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($urandom);
      q.push_back(d);
      stn.send(d, 1'h0, 1'h0, 1'h0, 1 + i % 2);
    end
    stn.send(8'h11, 1'h0, 1'h0, 1'h0, 1);
    stn.send(8'h22, 1'h0, 1'h0, 1'h0, 3);
    wr(8'h00, 32'h0000_0020, rs);
    wr(8'h08, 32'h0000_0006, rs);
    chk_w({rx_suspend, tx_suspend}, 2'h3);
    txc(8'h33, 1'h0, 10'h000);
    rdc(8'h00, 32'h0000_0029);
    rdc(8'h0C, 32'h0000_1000);
    wr(8'h00, 32'h0000_0020, rs);
    rdc(8'h00, 32'h0000_0028);
    foreach (q[i]) rdc(8'h10, {24'h00_0000, q[i]});
    for (int i = 0; i < 8; i++)
    begin
      nn = (i == 7) ? 255 : ((i >= 4) ? $urandom_range(3) : 0);
      wr(8'h04, 32'(nn), rs);
      wr(8'h00, 32'(cds[i] * 16), rs);
      wr(8'h08, 32'(1 + (i == 6) * 4 + pns[i] * 32), rs);
      meas(c);
      chk_w(c, exp_bit(nn, pns[i], cds[i], i == 6));
    end
    wr(8'h04, 32'h0000_0012, rs);
    standby <= 1'h1;
    repeat (2) @(posedge aclk);
    standby <= 1'h0;
    @(posedge aclk);
    rdc(8'h00, 32'h0000_0020);
    rdc(8'h04, 32'h0000_00FF);
    end_of_test();
  end
endmodule : ssbg_top_bench
